// >>> rgb_video_digitizer_control.sv
// Control logic of the triple 8-bit RGB video digitizer: clamp, gain, outputs, clocks.
//
// Contract
// - Per-channel 8-bit clamp code, half-LSB steps.
// - Clamp applies only while clamp pulse high.
// - Clamp code defaults to zero.
// - Output sample saturated into 0 to 255.
// - Calibrate gain every line before clamp.
// - Sync selects reference, else video input.
// - Compare sync result with coarse preset.
// - Three 7-bit coarse preset registers.
// - Per-channel 5-bit fine gain trim.
// - Samples during sync flagged invalid.
// - Per-channel out-of-range flag.
// - Output one clock after sampling.
// - Straight binary 8-bit, bit 7 MSB.
// - Output enable low drives, high releases.
// - Power-down input enters power-down.
// - Clock invert input inverts clock outputs.
// - Clock outputs follow sample and phase clocks; both carry one half-rate marker of pclk.
// - Reference pulse resynced, low eight periods.
module rgb_video_digitizer_control #(
  parameter int channels = video_digitizer_pkg::channel_count
) (
  input  wire logic        pclk,                  // Sampling clock
  input  wire logic        presetn,               // Async reset, active low
  input  wire logic        psel,                  // APB select
  input  wire logic        penable,               // APB enable
  input  wire logic        pwrite,                // APB direction
  input  wire logic [11:0] paddr,                 // APB byte address
  input  wire logic [31:0] pwdata,                // APB write data
  output logic      [31:0] prdata,                // APB read data
  output logic             pready,                // APB ready
  output logic             pslverr,               // APB error
  input  wire logic [26:0] adc_raw,               // Raw converter results, 9 bits per channel
  input  wire logic [2:0]  adc_over,              // Converter over full scale per channel
  input  wire logic        line_sync_in,          // Line sync level
  input  wire logic        clamp_pulse_in,        // Clamp pulse, active high
  input  wire logic        output_enable_n,       // Output enable, active low
  input  wire logic        power_down_in,         // Power-down request
  input  wire logic        clock_invert_in,       // Clock output invert command
  input  wire logic        ref_pulse_in,          // Reference pulse before resync
  output logic      [23:0] sample_out,            // Samples R[23:16] G[15:8] B[7:0]
  output logic      [23:0] sample_oe,             // Drive enable per sample bit
  output logic             sample_valid,          // Low for calibration samples
  output logic             red_over_range,        // Red out of range
  output logic             green_over_range,      // Green out of range
  output logic             blue_over_range,       // Blue out of range
  output logic             ref_select,            // Front end routes reference when high
  output logic             clamp_active,          // Clamp switch on
  output logic      [23:0] clamp_level,           // Clamp code per channel
  output logic      [20:0] coarse_gain,           // Live coarse gain per channel
  output logic      [14:0] fine_gain,             // Fine trim per channel
  output logic             power_down,            // Analog power-down
  output logic             sample_clock_out,      // In phase with sampling clock
  output logic             phase_a_clock_out,     // Same half-rate phase marker as sample_clock_out
  output logic             resync_ref_pulse_out   // Resynced reference, low 8 periods
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]  clamp_reg [channels];
  logic [6:0]  preset_reg [channels];
  logic [4:0]  fine_reg [channels];
  logic [7:0]  next_clamp_reg [channels];
  logic [6:0]  next_preset_reg [channels];
  logic [4:0]  next_fine_reg [channels];
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // Live coarse gain and calibration state
  logic [6:0]  gain_reg [channels];
  logic [6:0]  next_gain_reg [channels];
  logic        sync_seen;
  logic        next_sync_seen;
  logic [8:0]  sync_result [channels];
  logic [8:0]  next_sync_result [channels];
  logic        sync_prev;
  logic        next_sync_prev;

  logic        setup;
  assign setup = psel && !penable;

  // Writes wait for the access edge so that an aborted transfer changes nothing
  logic        access;
  assign access = psel && penable && pready;

  always_comb begin
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    for (int i = 0; i < channels; i++) begin
      next_clamp_reg[i]  = clamp_reg[i];
      next_preset_reg[i] = preset_reg[i];
      next_fine_reg[i]   = fine_reg[i];
    end
    // No wait state: answer in the first access cycle after setup
    if (setup) begin
      next_pready  = 1'b1;
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b1;
      for (int i = 0; i < channels; i++) begin
        if (paddr == video_digitizer_pkg::clamp_code_offset
                     + 12'(i) * video_digitizer_pkg::word_stride) begin
          next_pslverr = 1'b0;
          next_prdata  = {24'h000000, clamp_reg[i]};
        end
        if (paddr == video_digitizer_pkg::coarse_gain_offset
                     + 12'(i) * video_digitizer_pkg::word_stride) begin
          next_pslverr = 1'b0;
          next_prdata  = {25'h0000000, preset_reg[i]};
        end
        if (paddr == video_digitizer_pkg::fine_gain_offset
                     + 12'(i) * video_digitizer_pkg::word_stride) begin
          next_pslverr = 1'b0;
          next_prdata  = {27'h0000000, fine_reg[i]};
        end
        if (paddr == video_digitizer_pkg::coarse_state_offset
                     + 12'(i) * video_digitizer_pkg::word_stride) begin
          next_pslverr = pwrite;
          next_prdata  = {25'h0000000, gain_reg[i]};
        end
      end
      if (paddr == video_digitizer_pkg::status_offset) begin
        next_pslverr = pwrite;
        next_prdata  = {26'h0000000, sync_prev, clamp_pulse_in, power_down_in,
                        red_over_range, green_over_range, blue_over_range};
      end
      if (next_pslverr) next_prdata = 32'h0000_0000;
    end
    // Writes land at the access edge at which pready is seen high
    if (access && pwrite) begin
      for (int i = 0; i < channels; i++) begin
        if (paddr == video_digitizer_pkg::clamp_code_offset
                     + 12'(i) * video_digitizer_pkg::word_stride)
          next_clamp_reg[i] = pwdata[7:0];
        if (paddr == video_digitizer_pkg::coarse_gain_offset
                     + 12'(i) * video_digitizer_pkg::word_stride)
          next_preset_reg[i] = pwdata[6:0];
        if (paddr == video_digitizer_pkg::fine_gain_offset
                     + 12'(i) * video_digitizer_pkg::word_stride)
          next_fine_reg[i] = pwdata[4:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      for (int i = 0; i < channels; i++) begin
        clamp_reg[i]  <= video_digitizer_pkg::clamp_reset;
        preset_reg[i] <= video_digitizer_pkg::coarse_reset;
        fine_reg[i]   <= video_digitizer_pkg::fine_reset;
      end
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      for (int i = 0; i < channels; i++) begin
        clamp_reg[i]  <= next_clamp_reg[i];
        preset_reg[i] <= next_preset_reg[i];
        fine_reg[i]   <= next_fine_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Line calibration
  // ----------------------------------------------------------------
  // The last sync sample is compared on the falling edge of sync, so the
  // gain settles before the clamp pulse that follows in the same line.
  always_comb begin
    next_sync_prev = line_sync_in;
    next_sync_seen = sync_seen;
    for (int i = 0; i < channels; i++) begin
      next_gain_reg[i]    = gain_reg[i];
      next_sync_result[i] = sync_result[i];
      if (line_sync_in) next_sync_result[i] = adc_raw[9*i +: 9];
    end
    if (line_sync_in) next_sync_seen = 1'b1;
    if (sync_prev && !line_sync_in && sync_seen) begin
      next_sync_seen = 1'b0;
      for (int i = 0; i < channels; i++) begin
        // Comparison against the preset, one step per line
        if (sync_result[i] < {2'b00, preset_reg[i]}) begin
          if (gain_reg[i] != video_digitizer_pkg::coarse_max)
            next_gain_reg[i] = gain_reg[i] + 7'h01;
        end else if (sync_result[i] > {2'b00, preset_reg[i]}) begin
          if (gain_reg[i] != video_digitizer_pkg::coarse_min)
            next_gain_reg[i] = gain_reg[i] - 7'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_prev <= 1'b0;
      sync_seen <= 1'b0;
      for (int i = 0; i < channels; i++) begin
        gain_reg[i]    <= video_digitizer_pkg::coarse_reset;
        sync_result[i] <= 9'h000;
      end
    end else begin
      sync_prev <= next_sync_prev;
      sync_seen <= next_sync_seen;
      for (int i = 0; i < channels; i++) begin
        gain_reg[i]    <= next_gain_reg[i];
        sync_result[i] <= next_sync_result[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample pipeline and analog controls
  // ----------------------------------------------------------------
  logic [23:0] next_sample_out;
  logic [2:0]  next_over;
  logic [23:0] next_clamp_level;
  logic [20:0] next_coarse_gain;
  logic [14:0] next_fine_gain;
  logic [3:0]  ref_count;
  logic [3:0]  next_ref_count;
  logic        ref_prev;
  logic        next_ref_prev;
  logic        next_ref_out;

  always_comb begin
    for (int i = 0; i < channels; i++) begin
      // Raw results above full scale are limited; bit 7 stays the MSB
      if (adc_raw[9*i +: 9] > video_digitizer_pkg::sample_max)
        next_sample_out[8*i +: 8] = video_digitizer_pkg::sample_full;
      else
        next_sample_out[8*i +: 8] = adc_raw[9*i +: 8];
      next_over[i] = adc_over[i] || adc_raw[9*i+8];
      next_clamp_level[8*i +: 8] = clamp_reg[i];
      next_coarse_gain[7*i +: 7] = gain_reg[i];
      next_fine_gain[5*i +: 5]   = fine_reg[i];
    end
    // Resync on this clock, then hold low for the fixed period count
    next_ref_prev  = ref_pulse_in;
    next_ref_count = ref_count;
    if (ref_pulse_in && !ref_prev)
      next_ref_count = video_digitizer_pkg::ref_low_count;
    else if (ref_count != 4'h0)
      next_ref_count = ref_count - 4'h1;
    next_ref_out = (next_ref_count == 4'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_out           <= 24'h000000;
      sample_oe            <= 24'h000000;
      sample_valid         <= 1'b0;
      red_over_range       <= 1'b0;
      green_over_range     <= 1'b0;
      blue_over_range      <= 1'b0;
      ref_select           <= 1'b0;
      clamp_active         <= 1'b0;
      clamp_level          <= 24'h000000;
      coarse_gain          <= 21'h000000;
      fine_gain            <= 15'h0000;
      power_down           <= 1'b0;
      ref_count            <= 4'h0;
      ref_prev             <= 1'b0;
      resync_ref_pulse_out <= 1'b1;
    end else begin
      sample_out           <= next_sample_out;
      sample_oe            <= {24{!output_enable_n}};
      sample_valid         <= !line_sync_in;
      blue_over_range      <= next_over[0];
      green_over_range     <= next_over[1];
      red_over_range       <= next_over[2];
      ref_select           <= line_sync_in;
      clamp_active         <= clamp_pulse_in;
      clamp_level          <= next_clamp_level;
      coarse_gain          <= next_coarse_gain;
      fine_gain            <= next_fine_gain;
      power_down           <= power_down_in;
      ref_count            <= next_ref_count;
      ref_prev             <= next_ref_prev;
      resync_ref_pulse_out <= next_ref_out;
    end
  end

  // ----------------------------------------------------------------
  // Clock outputs
  // ----------------------------------------------------------------
  // A flip-flop cannot pass the clock itself; each output toggles at half
  // rate as a phase marker, inverted on command and stopped in power-down.
  logic next_sample_clock;
  logic next_phase_clock;
  logic clock_phase;

  always_comb begin
    next_sample_clock = (clock_phase ^ clock_invert_in) && !power_down_in;
    next_phase_clock  = (clock_phase ^ clock_invert_in) && !power_down_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_phase       <= 1'b0;
      sample_clock_out  <= 1'b0;
      phase_a_clock_out <= 1'b0;
    end else begin
      clock_phase       <= !clock_phase;
      sample_clock_out  <= next_sample_clock;
      phase_a_clock_out <= next_phase_clock;
    end
  end

endmodule : rgb_video_digitizer_control

// >>> video_digitizer_pkg.sv
// Constants, register map and types for the RGB video digitizer control block.
package video_digitizer_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [11:0] clamp_code_offset  = 12'h000;  // Three words, stride 4
  localparam logic [11:0] coarse_gain_offset = 12'h00C;  // Three words, stride 4
  localparam logic [11:0] fine_gain_offset   = 12'h018;  // Three words, stride 4
  localparam logic [11:0] status_offset      = 12'h024;
  localparam logic [11:0] coarse_state_offset = 12'h028; // Three words, stride 4
  localparam logic [11:0] word_stride        = 12'h004;

  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int          channel_count     = 3;
  localparam int          sample_width      = 8;
  localparam int          clamp_width       = 8;
  localparam int          coarse_width      = 7;
  localparam int          fine_width        = 5;
  localparam logic [7:0]  clamp_reset       = 8'h00;
  localparam logic [6:0]  coarse_reset      = 7'h20;
  localparam logic [4:0]  fine_reset        = 5'h00;
  localparam logic [6:0]  coarse_min        = 7'h00;
  localparam logic [6:0]  coarse_max        = 7'h7F;
  localparam logic [8:0]  sample_max        = 9'h0FF;
  localparam logic [7:0]  sample_full       = 8'hFF;
  localparam logic [7:0]  sample_zero       = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          ref_low_periods   = 8;
  localparam logic [3:0]  ref_low_count     = 4'(ref_low_periods);

  typedef enum logic [1:0] {
    line_video_type_idle,
    line_sync,
    line_clamp,
    line_video
  } line_phase_type;

endpackage : video_digitizer_pkg

// >>> pixel_sink.sv
// Downstream panel driver model that takes valid, driven pixels.
module pixel_sink (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [23:0] sample_out,
  input  wire logic [23:0] sample_oe,
  input  wire logic        sample_valid,
  output logic      [23:0] last_pixel,
  output logic      [15:0] pixel_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Calibration samples carry no picture, so they are dropped here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pixel  <= 24'h000000;
      pixel_count <= 16'h0000;
    end else if (sample_valid && (&sample_oe)) begin
      last_pixel  <= sample_out;
      pixel_count <= pixel_count + 16'h0001;
    end
  end
endmodule : pixel_sink

// >>> digitizer_sva.sv
// Concurrent checks on the digitizer control block ports.
module digitizer_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [26:0] adc_raw,
  input wire logic [2:0]  adc_over,
  input wire logic        line_sync_in,
  input wire logic        clamp_pulse_in,
  input wire logic        output_enable_n,
  input wire logic        power_down_in,
  input wire logic        clock_invert_in,
  input wire logic        ref_pulse_in,
  input wire logic [23:0] sample_out,
  input wire logic [23:0] sample_oe,
  input wire logic        sample_valid,
  input wire logic        red_over_range,
  input wire logic        green_over_range,
  input wire logic        blue_over_range,
  input wire logic        ref_select,
  input wire logic        clamp_active,
  input wire logic        power_down,
  input wire logic        sample_clock_out,
  input wire logic        phase_a_clock_out,
  input wire logic        resync_ref_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic [7:0] sat(input logic [8:0] r);
    return r[8] ? 8'hFF : r[7:0];
  endfunction : sat
  property p_sample;
    1'b1 |=> sample_out == {sat($past(adc_raw[26:18])), sat($past(adc_raw[17:9])),
                            sat($past(adc_raw[8:0]))};
  endproperty
  a_sample: assert property (p_sample) else $error("sample word wrong");
  property p_over;
    1'b1 |=> {red_over_range, green_over_range, blue_over_range} ==
             ($past(adc_over) | $past({adc_raw[26], adc_raw[17], adc_raw[8]}));
  endproperty
  a_over: assert property (p_over) else $error("over-range flag wrong");
  property p_valid;
    line_sync_in |=> !sample_valid && ref_select;
  endproperty
  a_valid: assert property (p_valid) else $error("sync sample not marked");
  property p_route;
    !line_sync_in |=> !ref_select && sample_valid;
  endproperty
  a_route: assert property (p_route) else $error("selector wrong");
  property p_clamp;
    1'b1 |=> clamp_active == $past(clamp_pulse_in);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp switch wrong");
  property p_oe;
    1'b1 |=> sample_oe == {24{!$past(output_enable_n)}};
  endproperty
  a_oe: assert property (p_oe) else $error("output drive wrong");
  property p_pd;
    power_down_in [*2] |=> power_down && !sample_clock_out && !phase_a_clock_out;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down wrong");
  property p_toggle;
    $past(presetn) && !power_down_in && !$past(power_down_in) && $stable(clock_invert_in) |=>
      sample_clock_out != $past(sample_clock_out) &&
      phase_a_clock_out != $past(phase_a_clock_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("clock output stalled");
  property p_invert;
    $past(presetn) && !power_down_in && !$past(power_down_in) && $changed(clock_invert_in) |=>
      sample_clock_out == $past(sample_clock_out) &&
      phase_a_clock_out == $past(phase_a_clock_out);
  endproperty
  a_invert: assert property (p_invert) else $error("clock invert ignored");
  property p_ref;
    $rose(ref_pulse_in) |=> !resync_ref_pulse_out [*8] ##1 resync_ref_pulse_out;
  endproperty
  a_ref: assert property (p_ref) else $error("reference pulse width wrong");
  c_ref: cover property ($rose(ref_pulse_in));
  c_sat: cover property (adc_raw[8] ##1 sample_out[7:0] == 8'hFF);
  c_sync: cover property ($fell(line_sync_in));
endmodule : digitizer_sva

// >>> rgb_video_digitizer_control_test.sv
// Self-checking bench for the digitizer control block.
module rgb_video_digitizer_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er;
  logic [26:0] adc_raw = 27'h0;
  logic [2:0]  adc_over = 3'h0;
  logic        line_sync_in = 1'b0, clamp_pulse_in = 1'b0, output_enable_n = 1'b0;
  logic        power_down_in = 1'b0, clock_invert_in = 1'b0, ref_pulse_in = 1'b0;
  logic [23:0] sample_out, sample_oe, clamp_level, last_pixel;
  logic        sample_valid, red_over_range, green_over_range, blue_over_range;
  logic        ref_select, clamp_active, power_down, resync_ref_pulse_out;
  logic        sample_clock_out, phase_a_clock_out;
  logic [20:0] coarse_gain;
  logic [14:0] fine_gain;
  logic [15:0] pixel_count, cnt;
  logic [8:0]  v;
  logic [7:0]  e;
  int          err_total = 0, n_tests = 0, n;
  always #5 pclk = ~pclk;
  rgb_video_digitizer_control DUT (.*);
  pixel_sink sink (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Request held from setup until pready is seen high at a rising edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50) begin
      err_total++;
      $display("MISMATCH at %0t: no pready from slave", $time);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #100us;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      xfer(video_digitizer_pkg::clamp_code_offset + 12'(4 * i), 1'b0, 32'h0);
      check(rd, 32'h0);
      xfer(video_digitizer_pkg::coarse_gain_offset + 12'(4 * i), 1'b0, 32'h0);
      check(rd, 32'h20);
      xfer(video_digitizer_pkg::fine_gain_offset + 12'(4 * i), 1'b0, 32'h0);
      check(rd, 32'h0);
      xfer(video_digitizer_pkg::clamp_code_offset + 12'(4 * i), 1'b1, 32'h1A0 + i);
      xfer(video_digitizer_pkg::clamp_code_offset + 12'(4 * i), 1'b0, 32'h0);
      check(rd, 32'hA0 + i);
      check(32'(clamp_level[8 * i +: 8]), 32'hA0 + i);
      xfer(video_digitizer_pkg::coarse_gain_offset + 12'(4 * i), 1'b1, 32'h63);
      xfer(video_digitizer_pkg::fine_gain_offset + 12'(4 * i), 1'b1, 32'h3F);
      xfer(video_digitizer_pkg::fine_gain_offset + 12'(4 * i), 1'b0, 32'h0);
      check(rd, 32'h1F);
      check(32'(fine_gain[5 * i +: 5]), 32'h1F);
    end
    xfer(12'h034, 1'b0, 32'h0);
    check({rd[30:0], er}, 32'h1);
    xfer(video_digitizer_pkg::status_offset, 1'b1, 32'h3F);
    check(32'(er), 32'h1);
    $display("Registers done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 9'h1FF : (i == 1) ? 9'h100 : (i == 2) ? 9'h0FF : 9'(i * 8'h41);
      e = v[8] ? 8'hFF : v[7:0];
      @(posedge pclk);
      adc_raw <= {v, v, v};
      @(posedge pclk);
      #1;
      check(32'(sample_out), 32'({e, e, e}));
      check(32'({red_over_range, green_over_range, blue_over_range}), 32'({3{v[8]}}));
    end
    @(posedge pclk);
    output_enable_n <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    check(32'(sample_oe), 32'h0);
    check(32'(last_pixel), 32'({e, e, e}));
    @(posedge pclk);
    output_enable_n <= 1'b0;
    $display("Samples done");
    for (int i = 0; i < 3; i++) begin
      xfer(video_digitizer_pkg::coarse_gain_offset + 12'(4 * i), 1'b1, i == 0 ? 32'h22 : 32'h20);
    end
    repeat (2) begin
      @(posedge pclk);
      line_sync_in <= 1'b1;
      adc_raw      <= {9'h020, 9'h07F, 9'h010};
      repeat (2) @(posedge pclk);
      #1;
      check(32'(sample_valid), 32'h0);
      cnt = pixel_count;
      repeat (2) @(posedge pclk);
      #1;
      check(32'(pixel_count), 32'(cnt));
      @(posedge pclk);
      line_sync_in   <= 1'b0;
      adc_raw        <= 27'h0;
      repeat (3) @(posedge pclk);
      clamp_pulse_in <= 1'b1;
      repeat (2) @(posedge pclk);
      clamp_pulse_in <= 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      xfer(video_digitizer_pkg::coarse_state_offset + 12'(4 * i), 1'b0, 32'h0);
      e = (i == 0) ? 8'h22 : (i == 1) ? 8'h1E : 8'h20;
      check(rd, 32'(e));
      check(32'(coarse_gain[7 * i +: 7]), 32'(e));
    end
    $display("Calibration done");
    @(posedge pclk);
    clamp_pulse_in <= 1'b1;
    power_down_in  <= 1'b1;
    adc_over       <= 3'b101;
    repeat (4) @(posedge pclk);
    xfer(video_digitizer_pkg::status_offset, 1'b0, 32'h0);
    check(rd, 32'h1D);
    check(32'({power_down, sample_clock_out}), 32'h2);
    clamp_pulse_in  <= 1'b0;
    power_down_in   <= 1'b0;
    adc_over        <= 3'b000;
    repeat (3) @(posedge pclk);
    #1;
    e = {6'h00, sample_clock_out, phase_a_clock_out};
    @(posedge pclk);
    clock_invert_in <= 1'b1;
    @(posedge pclk);
    #1;
    check(32'({sample_clock_out, phase_a_clock_out}), 32'(e[1:0] ^ 2'b11));
    @(posedge pclk);
    ref_pulse_in <= 1'b1;
    @(posedge pclk);
    ref_pulse_in <= 1'b0;
    n = 0;
    repeat (20) begin
      #1;
      if (resync_ref_pulse_out === 1'b0) n++;
      @(posedge pclk);
    end
    check(32'(n), 32'd8);
    $display("Clocks and reference done");
    report_and_stop();
  end
endmodule : rgb_video_digitizer_control_test
bind rgb_video_digitizer_control digitizer_sva chk (.*);
